// *** src/acs_regs.svh ***
// Register layout and timing constants of the conversion sequencer
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
`define ACS_CH_LSB      0
`define ACS_CH_MSB      2
`define ACS_TEST_BIT    5
`define ACS_SPAN_BIT    6
`define ACS_AUTO_BIT    7
`define ACS_STEP_BIT    8
`define ACS_SLEEP_BIT   9
`define ACS_DONE_BIT    10
`define ACS_CH_LAST     3'h6
`define ACS_CH_FIRST    3'h0
`define ACS_CONV_STEPS  4'hd
`define ACS_DIV_FAST    4'h4
`define ACS_DIV_SLOW    4'h8
`define ACS_SAR_MSB     4'h9
`define ACS_RESULT_RST  10'h000
`endif

// *** src/acs_pkg.sv ***
// Types shared by the conversion sequencer
`default_nettype none
package acs_pkg;
    typedef enum logic [2:0] {
        ACS_IDLE   = 3'b001,
        ACS_SAMPLE = 3'b010,
        ACS_CONV   = 3'b100
    } acs_state_type;
endpackage
`default_nettype wire

// *** src/acs_sar_if.sv ***
// Carrier between sequencer and SAR register
`timescale 1ns/1ps
`default_nettype none
interface acs_sar_if;
    logic       start;
    logic       step;
    logic       cmp_hi;
    logic [9:0] trial;
    logic [9:0] code;
    logic       done;
    modport ctl (output start, output step, input trial, input code,
                 input done);
    modport sar (input start, input step, input cmp_hi, output trial,
                 output code, output done);
endinterface
`default_nettype wire

// *** src/acs_sar.sv ***
// Successive-approximation register, one bit per step
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
module acs_sar (
    input  wire logic sys_clk,  // System clock
    input  wire logic rst_b,    // Async reset, active low
    acs_sar_if.sar    bus       // Sequencer side
);
    logic [9:0] bits_ff;
    logic [3:0] idx_ff;
    logic       run_ff;
    logic       done_ff;

    // MSB first; comparator judges the trial word
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bits_ff <= `ACS_RESULT_RST;
            idx_ff  <= 4'h0;
            run_ff  <= 1'b0;
            done_ff <= 1'b0;
        end else if (bus.start) begin
            bits_ff <= `ACS_RESULT_RST;
            idx_ff  <= `ACS_SAR_MSB;
            run_ff  <= 1'b1;
            done_ff <= 1'b0;
        end else if (run_ff && bus.step) begin
            bits_ff[idx_ff] <= bus.cmp_hi;
            if (idx_ff == 4'h0) begin
                run_ff  <= 1'b0;
                done_ff <= 1'b1;
            end else begin
                idx_ff <= idx_ff - 4'h1;
            end
        end
    end

    always_comb begin
        bus.trial = bits_ff;
        if (run_ff) begin
            bus.trial[idx_ff] = 1'b1;
        end
    end
    // Offset binary inside, two's complement outside
    assign bus.code = {~bits_ff[9], bits_ff[8:0]};
    assign bus.done = done_ff;
endmodule
`default_nettype wire

// *** src/acs_top.sv ***
// Conversion sequencer for the seven-input signed 10-bit converter
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
// Summary of operation
// - Signed 10-bit SAR, MSB first
// - Write bits 2..0 pick channel
// - Codes 0..6 select channels 0..6
// - Code 7 connects no input
// - Bit 6 chooses narrow or wide span
// - Result is two's complement, mid zero
// - Every write samples and starts conversion
// - Read bit 10 is done flag
// - Auto plus step: read converts next channel
// - Auto only: read converts same channel
// - No auto: reads never start conversions
// - Auto bit overrides step bit
// - Mode bits zero after reset
// - Bit 9 puts aux amps to sleep
// - 13 step clocks, divide by 8 or 4
module acs_top
    import acs_pkg::*;
(
    input  wire logic        sys_clk,                     // Master clock
    input  wire logic        rst_b,                       // Async reset
    input  wire logic        wr_stb,                      // Register write
    input  wire logic [11:0] wr_data,                     // Write word
    input  wire logic        rd_stb,                      // Result read done
    input  wire logic        slow_converter_clock_select, // 1: divide by 8
    input  wire logic        cmp_hi,                      // Comparator out
    output logic      [11:0] rd_data,                     // Read word
    output logic      [2:0]  input_channel_code,          // Mux address
    output logic             mux_enable,                  // Mux connected
    output logic             sample_hold,                 // Track input
    output logic      [9:0]  dac_trial,                   // SAR DAC word
    output logic             input_span_choice,           // 1: 0..5 V
    output logic             converter_test_enable,       // DAC test
    output logic             aux_amp_sleep,               // Amps asleep
    output logic             auto_repeat_enable,          // Auto mode
    output logic             channel_step_enable          // Increment mode
);
    import acs_pkg::*;

    acs_sar_if sar_bus ();
    acs_sar u_sar (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .bus     (sar_bus)
    );
    assign sar_bus.cmp_hi = cmp_hi;

    function automatic logic [2:0] next_chan(input logic [2:0] ch);
        // Never steps onto the illegal code
        next_chan = (ch >= `ACS_CH_LAST) ? `ACS_CH_FIRST : ch + 3'h1;
    endfunction

    // ========================================================
    // Control register
    // ========================================================
    logic [2:0]    chan_ff;
    logic          span_ff;
    logic          test_ff;
    logic          auto_ff;
    logic          step_ff;
    logic          sleep_ff;
    logic          relaunch;
    logic [2:0]    nxt_chan;
    acs_state_type state_ff;

    // Auto bit has priority; step alone is ignored
    assign relaunch = rd_stb && auto_ff && (state_ff == ACS_IDLE);
    assign nxt_chan = step_ff ? next_chan(chan_ff) : chan_ff;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            chan_ff  <= 3'h0;
            span_ff  <= 1'b0;
            test_ff  <= 1'b0;
            auto_ff  <= 1'b0;
            step_ff  <= 1'b0;
            sleep_ff <= 1'b0;
        end else if (wr_stb) begin
            // Bits 3, 4, 10, 11 are dropped
            chan_ff  <= wr_data[`ACS_CH_MSB:`ACS_CH_LSB];
            test_ff  <= wr_data[`ACS_TEST_BIT];
            span_ff  <= wr_data[`ACS_SPAN_BIT];
            auto_ff  <= wr_data[`ACS_AUTO_BIT];
            step_ff  <= wr_data[`ACS_STEP_BIT];
            sleep_ff <= wr_data[`ACS_SLEEP_BIT];
        end else if (relaunch) begin
            chan_ff <= nxt_chan;
        end
    end

    // ========================================================
    // Step clock divider
    // ========================================================
    logic [3:0] div_ff;
    logic       tick;
    logic [3:0] div_n;
    assign div_n = slow_converter_clock_select ? `ACS_DIV_SLOW
                                               : `ACS_DIV_FAST;
    assign tick  = (div_ff == div_n - 4'h1);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_ff <= 4'h0;
        end else if (tick || div_ff >= div_n || state_ff == ACS_IDLE) begin
            div_ff <= 4'h0;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
    end

    // ========================================================
    // Sequencer
    // ========================================================
    logic [3:0] cnt_ff;
    logic       start_req;
    assign start_req = wr_stb || relaunch;

    // 13 step periods: 3 sample/settle, 10 bit decisions
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ACS_IDLE;
            cnt_ff   <= 4'h0;
        end else if (start_req) begin
            state_ff <= ACS_SAMPLE;
            cnt_ff   <= 4'h0;
        end else if (tick) begin
            cnt_ff <= cnt_ff + 4'h1;
            case (state_ff)
                ACS_SAMPLE: begin
                    if (cnt_ff == `ACS_CONV_STEPS - `ACS_SAR_MSB - 4'h2) begin
                        state_ff <= ACS_CONV;
                    end
                end
                ACS_CONV: begin
                    if (cnt_ff == `ACS_CONV_STEPS - 4'h1) begin
                        state_ff <= ACS_IDLE;
                    end
                end
                default: begin
                    state_ff <= ACS_IDLE;
                end
            endcase
        end
    end

    logic sar_go;
    assign sar_bus.start = sar_go;
    assign sar_bus.step  = tick && (state_ff == ACS_CONV);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sar_go <= 1'b0;
        end else begin
            sar_go <= start_req;
        end
    end

    // ========================================================
    // Outputs
    // ========================================================
    logic busy;
    assign busy = start_req || (state_ff != ACS_IDLE) || sar_go;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data            <= 12'h000;
            input_channel_code <= 3'h0;
            mux_enable         <= 1'b0;
            sample_hold        <= 1'b0;
            dac_trial          <= 10'h000;
        end else begin
            // Done low while running; upper bit always zero
            rd_data <= {1'b0, ~busy && sar_bus.done,
                        sar_bus.code};
            input_channel_code <= start_req && !wr_stb ? nxt_chan
                                : wr_stb ? wr_data[`ACS_CH_MSB:`ACS_CH_LSB]
                                : chan_ff;
            // Illegal code leaves the mux open
            mux_enable <= (start_req && !wr_stb ? nxt_chan
                          : wr_stb ? wr_data[`ACS_CH_MSB:`ACS_CH_LSB]
                          : chan_ff) <= `ACS_CH_LAST;
            sample_hold <= start_req || (state_ff == ACS_SAMPLE);
            dac_trial   <= sar_bus.trial;
        end
    end

    assign input_span_choice     = span_ff;
    assign converter_test_enable = test_ff;
    assign aux_amp_sleep         = sleep_ff;
    assign auto_repeat_enable    = auto_ff;
    assign channel_step_enable   = step_ff;

    // ========================================================
    // Checks
    // ========================================================
    a_reset_mode_zero: assert property (
        @(posedge sys_clk) $rose(rst_b) |-> !auto_ff && !step_ff)
        else $error("mode bits not zero after reset");
    a_write_starts: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        wr_stb |=> state_ff == ACS_SAMPLE)
        else $error("write did not start conversion");
    a_busy_flag: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        wr_stb |=> !rd_data[`ACS_DONE_BIT])
        else $error("done flag high while converting");
    a_single_no_read: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        rd_stb && !auto_ff && !wr_stb && state_ff == ACS_IDLE
        |=> state_ff == ACS_IDLE)
        else $error("read launched conversion in single mode");
    a_step_wrap: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        relaunch && step_ff && !wr_stb && chan_ff == `ACS_CH_LAST
        |=> chan_ff == `ACS_CH_FIRST)
        else $error("channel did not wrap");
    a_same_chan: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        relaunch && !step_ff && !wr_stb |=> $stable(chan_ff))
        else $error("channel changed in repeat mode");
    a_conv_length: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        wr_stb && !slow_converter_clock_select ##1
        (!wr_stb && !rd_stb && !slow_converter_clock_select)[*8]
        |-> state_ff != ACS_IDLE)
        else $error("conversion ended early");
    a_illegal_mux: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        wr_stb && wr_data[`ACS_CH_MSB:`ACS_CH_LSB] == 3'h7 |=> !mux_enable)
        else $error("illegal channel connected");
endmodule
`default_nettype wire

// *** testbench/acs_analog_model.sv ***
// Comparator and input mux model seen by the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model (
    input  wire logic        sys_clk,            // Master clock
    input  wire logic [2:0]  input_channel_code, // Mux address
    input  wire logic        mux_enable,         // Mux connected
    input  wire logic [9:0]  dac_trial,          // SAR DAC word
    input  wire logic [79:0] levels,             // Offset-binary inputs
    output logic             cmp_hi              // Input at or above trial
);
    logic noise_ff;

    // No input connected: output wanders every cycle
    // Plain always: the initial block below also writes this variable
    always @(posedge sys_clk) begin
        noise_ff <= ~noise_ff;
    end

    always_comb begin
        if (mux_enable) begin
            cmp_hi = levels[input_channel_code*10 +: 10] >= dac_trial;
        end else begin
            cmp_hi = noise_ff;
        end
    end

    initial noise_ff = 1'b0;
endmodule
`default_nettype wire

// *** testbench/acs_top_tb.sv ***
// Self-checking testbench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module acs_top_tb;
    logic        sys_clk = 0;
    logic        rst_b   = 0;
    logic        wr_stb  = 0;
    logic        rd_stb  = 0;
    logic        slow_sel = 0;
    logic [11:0] wr_data = 0;
    logic [79:0] levels  = 0;
    logic [11:0] rd_data;
    logic [2:0]  ch_code;
    logic [9:0]  trial;
    logic        mux_en, s_h, span, test_en, sleep, auto_en, step_en;
    logic        cmp_hi;
    int          failures  = 0;
    int          cmp_count = 0;
    int          n;

    acs_top acs_top_i (.sys_clk(sys_clk), .rst_b(rst_b), .wr_stb(wr_stb),
        .wr_data(wr_data), .rd_stb(rd_stb),
        .slow_converter_clock_select(slow_sel), .cmp_hi(cmp_hi),
        .rd_data(rd_data), .input_channel_code(ch_code),
        .mux_enable(mux_en), .sample_hold(s_h), .dac_trial(trial),
        .input_span_choice(span), .converter_test_enable(test_en),
        .aux_amp_sleep(sleep), .auto_repeat_enable(auto_en),
        .channel_step_enable(step_en));

    acs_analog_model acs_analog_model_i (.sys_clk(sys_clk),
        .input_channel_code(ch_code), .mux_enable(mux_en),
        .dac_trial(trial), .levels(levels), .cmp_hi(cmp_hi));

    always #4 sys_clk = ~sys_clk;

    // ==========================================================
    // Host-side tasks
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic pulse_wr(input logic [11:0] d);
        @(posedge sys_clk);
        #1;
        wr_stb  = 1'b1;
        wr_data = d;
        @(posedge sys_clk);
        #1;
        wr_stb = 1'b0;
        `CHK(rd_data[10], 1'b0)
        `CHK(s_h, 1'b1)
    endtask

    task automatic pulse_rd;
        @(posedge sys_clk);
        #1;
        rd_stb = 1'b1;
        @(posedge sys_clk);
        #1;
        rd_stb = 1'b0;
    endtask

    // Bounded wait for the done flag; n counts cycles spent
    task automatic wait_done;
        n = 0;
        while (rd_data[10] !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 400) begin
                failures++;
                finish_test();
            end
        end
    endtask

    task automatic expect_result(input int ch);
        wait_done();
        `CHK(ch_code, 3'(ch))
        `CHK(mux_en, 1'b1)
        `CHK(s_h, 1'b0)
        `CHK(rd_data, {2'b01, levels[ch*10 +: 10] ^ 10'h200})
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [11:0] d;
        int          t;
        void'($urandom(32'hccd4));
        for (int i = 0; i < 7; i++) begin
            levels[i*10 +: 10] = 10'($urandom);
        end
        repeat (16) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        `CHK(rd_data, 12'h000)
        `CHK({auto_en, step_en, sleep, span}, 4'h0)
        pulse_wr(12'h020);
        `CHK(test_en, 1'b1)
        wait_done();
        pulse_wr(12'h000);
        wait_done();
        `CHK(test_en, 1'b0)
        // Single mode, random span, sleep and unused bits 3, 10, 11, odd passes set step alone
        for (int c = 0; c < 7; c++) begin
            d = 12'(($urandom & 32'he48) | ((c & 1) << 8) | c);
            pulse_wr(d);
            expect_result(c);
            `CHK(span, d[6])
            `CHK(sleep, d[9])
            pulse_rd();
            repeat (3) begin
                @(posedge sys_clk);
                #1;
                `CHK(rd_data[10], 1'b1)
            end
        end
        // Auto repeat keeps the written channel
        pulse_wr(12'h083);
        expect_result(3);
        `CHK({auto_en, step_en}, 2'b10)
        levels[39:30] = ~levels[39:30];
        pulse_rd();
        `CHK(rd_data[10], 1'b0)
        expect_result(3);
        // Stepping from five wraps past six
        pulse_wr(12'h185);
        expect_result(5);
        `CHK({auto_en, step_en}, 2'b11)
        pulse_rd();
        expect_result(6);
        pulse_rd();
        expect_result(0);
        pulse_wr(12'h007);
        `CHK(mux_en, 1'b0)
        wait_done();
        // Conversion length for both dividers
        for (int s = 0; s < 2; s++) begin
            slow_sel = s[0];
            pulse_wr(12'h002);
            wait_done();
            t = s ? 8 : 4;
            `CHK(n >= 13*t - 2 && n <= 13*t + 4, 1'b1)
        end
        finish_test();
    end
endmodule
`default_nettype wire
